// ==== logic/upc_regs.sv ====
// USB port and PHY control register bank in configuration space
//
// Summary of operation
// - Bit 31 set stops clock spread spectrum
// - Writing 1 to bit 30 restarts oscillator
// - Bit 30 takes one write per power-up
// - PLL field drives PLL only with strap high
// - PLL field locked once bit 30 set
// - Hide bit blanks MSI-X pointer and BARs
// - Polarity bit picks power pin level, pulldowns
// - Switch-absent bit clears reported power-switch capability
// - Reserved ranges 21:17, 15:12 read zero
// - Port disable bits 11:8 turn ports off
// - Ports 3, 4 inert in two-port variant
// - Bits 7:4 force SuperSpeed removable flag
// - Bits 3:0 force high-speed removable flag
// - Any reset clears non-sticky fields
// - Sticky fields survive fundamental reset only
// - Amplitude override takes per-port amplitude field
// - De-emphasis override takes per-port de-emphasis field
// - Override bit picks default or register amplitude
// - Equalizer override takes training, operational values
`include "upc_map.svh"
`default_nettype none

module upc_regs #(
  parameter int unsigned       NUM_PORTS    = 4,   // 2 for the two-port variant
  parameter upc_pkg::upc_fld_t DEF_AMP      = 4'h0,
  parameter upc_pkg::upc_fld_t DEF_DE       = 4'h0,
  parameter upc_pkg::upc_fld_t DEF_EQ_TRAIN = 4'h0,
  parameter upc_pkg::upc_fld_t DEF_EQ_OPER  = 4'h0
) (
  input  wire logic                  sys_clk_i,
  input  wire logic                  nrst_i,
  input  wire logic                  perst_n_i,
  input  wire logic                  global_reset_n_i,
  input  wire logic                  freq_strap_pin_i,
  input  wire upc_pkg::upc_cfg_req_t cfg_req_i,
  output logic                       cfg_ack_o,
  output logic                       cfg_hit_o,
  output logic [31:0]                cfg_rdata_o,
  input  wire logic [3:0]            port_power_req_i,
  output logic [3:0]                 port_power_out_pin_o,
  output logic                       port_power_pulldown_en_o,
  output logic                       ssc_disable_o,
  output logic                       osc_restart_o,
  output logic [5:0]                 pll_ratio_o,
  output logic [5:0]                 osc_sel_o,
  output logic                       msgx_capability_hide_o,
  output logic                       power_switch_capable_o,
  output logic [3:0]                 port_off_o,
  output logic [3:0]                 ss_port_fixed_o,
  output logic [3:0]                 hs_port_fixed_o,
  output upc_pkg::upc_port_phy_t     port_phy_o [4]
);

  // ============================================================
  // Pin synchronisers
  // ============================================================
  logic [2:0] pins_sync;    // {strap, global reset n, fundamental reset n}
  logic       perst_ok;     // Fundamental reset released
  logic       global_reset_n_ok;      // Global reset released
  logic       strap_s;      // Frequency strap level

  upc_sync #(
    .WIDTH (3)
  ) u_pin_sync (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .async_i   ({freq_strap_pin_i, global_reset_n_i, perst_n_i}),
    .sync_o    (pins_sync)
  );

  assign perst_ok = pins_sync[0];
  assign global_reset_n_ok  = pins_sync[1];
  assign strap_s  = pins_sync[2];

  // ============================================================
  // Register state
  // ============================================================
  logic        ssc_q,     ssc_d;       // Spread-spectrum disable
  logic        commit_q,  commit_d;    // Frequency commit, sticky
  logic [5:0]  pll_q,     pll_d;       // PLL ratio field, sticky
  logic        hide_q,    hide_d;      // MSI-X hide
  logic        pol_q,     pol_d;       // Power pin polarity, sticky
  logic        absent_q,  absent_d;    // Power switch absent
  logic [3:0]  off_q,     off_d;       // Per-port disables
  logic [3:0]  ssfix_q,   ssfix_d;     // SuperSpeed non-removable
  logic [3:0]  hsfix_q,   hsfix_d;     // High-speed non-removable
  logic [31:0] tx_q,      tx_d;        // Amplitude and de-emphasis
  logic [31:0] eq_q,      eq_d;        // Equalizer values
  logic [31:0] ovr_q,     ovr_d;       // Override enables
  logic        once_q,    once_d;      // Commit chance used; only power-on clears it
  logic        restart_q, restart_d;   // Oscillator restart pulse
  logic        ack_q,     ack_d;
  logic        hit_q,     hit_d;
  logic [31:0] rdata_q,   rdata_d;

  logic        wr_usb;                 // Write strobes per register
  logic        wr_tx;
  logic        wr_eq;
  logic        wr_ovr;
  logic [31:0] usb_view;               // Readback of the general register
  logic [31:0] usb_new;                // General register after byte merge

  // Byte-enable merge of a configuration write
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] be);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
      begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction : merge

  // Reserved ranges are not stored, so they always read zero
  assign usb_view = {ssc_q, commit_q, pll_q, hide_q, pol_q, 5'h00,
                     absent_q, 4'h0, off_q, ssfix_q, hsfix_q};
  assign usb_new  = merge(usb_view, cfg_req_i.wdata, cfg_req_i.be);

  assign wr_usb = cfg_req_i.req && cfg_req_i.we && (cfg_req_i.addr == `UPC_OFF_USB_CTRL);
  assign wr_tx  = cfg_req_i.req && cfg_req_i.we && (cfg_req_i.addr == `UPC_OFF_TX_CTRL);
  assign wr_eq  = cfg_req_i.req && cfg_req_i.we && (cfg_req_i.addr == `UPC_OFF_EQ_CTRL);
  assign wr_ovr = cfg_req_i.req && cfg_req_i.we && (cfg_req_i.addr == `UPC_OFF_OVR_CTRL);

  // ============================================================
  // Register next values: writes, then the synchronous resets
  // ============================================================
  always_comb
  begin
    ssc_d     = ssc_q;
    commit_d  = commit_q;
    pll_d     = pll_q;
    hide_d    = hide_q;
    pol_d     = pol_q;
    absent_d  = absent_q;
    off_d     = off_q;
    ssfix_d   = ssfix_q;
    hsfix_d   = hsfix_q;
    tx_d      = tx_q;
    eq_d      = eq_q;
    ovr_d     = ovr_q;
    once_d    = once_q;
    restart_d = 1'b0;
    if (wr_usb)
    begin
      ssc_d    = usb_new[`UPC_BIT_SSC_DIS];
      hide_d   = usb_new[`UPC_BIT_MSGX_HIDE];
      pol_d    = usb_new[`UPC_BIT_PWR_POL];
      absent_d = usb_new[`UPC_BIT_PSW_ABSENT];
      off_d    = usb_new[`UPC_POS_OFF_LO +: 4];
      ssfix_d  = usb_new[`UPC_POS_SS_FIX_LO +: 4];
      hsfix_d  = usb_new[`UPC_POS_HS_FIX_LO +: 4];
      // The ratio may still change in the very write that commits it
      if (!commit_q)
      begin
        pll_d = usb_new[`UPC_POS_PLL_HI:`UPC_POS_PLL_LO];
      end
      // Only the first write of 1 lands; later ones are dropped silently
      if (cfg_req_i.be[`UPC_BYTE_COMMIT] && cfg_req_i.wdata[`UPC_BIT_FREQ_COMMIT] && !once_q)
      begin
        commit_d  = 1'b1;
        once_d    = 1'b1;
        restart_d = 1'b1;
      end
    end
    if (wr_tx)
    begin
      tx_d = merge(tx_q, cfg_req_i.wdata, cfg_req_i.be);
    end
    if (wr_eq)
    begin
      eq_d = merge(eq_q, cfg_req_i.wdata, cfg_req_i.be);
    end
    if (wr_ovr)
    begin
      ovr_d = merge(ovr_q, cfg_req_i.wdata, cfg_req_i.be) & `UPC_OVR_MASK;
    end
    // Either reset pin clears the ordinary fields
    if (!perst_ok || !global_reset_n_ok)
    begin
      ssc_d     = 1'b0;
      hide_d    = 1'b0;
      absent_d  = 1'b0;
      off_d     = 4'h0;
      ssfix_d   = 4'h0;
      hsfix_d   = 4'h0;
      tx_d      = `UPC_RST_TX_CTRL;
      eq_d      = `UPC_RST_EQ_CTRL;
      ovr_d     = `UPC_RST_OVR_CTRL;
      restart_d = 1'b0;
    end
    // Sticky fields follow the global reset alone
    if (!global_reset_n_ok)
    begin
      commit_d = 1'b0;
      pll_d    = 6'h00;
      pol_d    = 1'b0;
    end
  end

  // Power-on clears everything, the write-once history included
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      {ssc_q, commit_q, pll_q, hide_q, pol_q} <= 10'h000;
      {absent_q, off_q, ssfix_q, hsfix_q}     <= 13'h0000;
      tx_q      <= `UPC_RST_TX_CTRL;
      eq_q      <= `UPC_RST_EQ_CTRL;
      ovr_q     <= `UPC_RST_OVR_CTRL;
      once_q    <= 1'b0;
      restart_q <= 1'b0;
    end
    else
    begin
      ssc_q     <= ssc_d;
      commit_q  <= commit_d;
      pll_q     <= pll_d;
      hide_q    <= hide_d;
      pol_q     <= pol_d;
      absent_q  <= absent_d;
      off_q     <= off_d;
      ssfix_q   <= ssfix_d;
      hsfix_q   <= hsfix_d;
      tx_q      <= tx_d;
      eq_q      <= eq_d;
      ovr_q     <= ovr_d;
      once_q    <= once_d;
      restart_q <= restart_d;
    end
  end

  // ============================================================
  // Read and acknowledge, one cycle after the request
  // ============================================================
  always_comb
  begin
    ack_d   = cfg_req_i.req;
    hit_d   = 1'b0;
    rdata_d = 32'h0000_0000;
    if (cfg_req_i.req)
    begin
      case (cfg_req_i.addr)
        `UPC_OFF_USB_CTRL:
        begin
          hit_d   = 1'b1;
          rdata_d = usb_view;
        end
        `UPC_OFF_TX_CTRL:
        begin
          hit_d   = 1'b1;
          rdata_d = tx_q;
        end
        `UPC_OFF_EQ_CTRL:
        begin
          hit_d   = 1'b1;
          rdata_d = eq_q;
        end
        `UPC_OFF_OVR_CTRL:
        begin
          hit_d   = 1'b1;
          rdata_d = ovr_q;
        end
        // Other addresses belong to other banks: no hit, zero data
        default:
        begin
          hit_d   = 1'b0;
          rdata_d = 32'h0000_0000;
        end
      endcase
    end
    if (cfg_req_i.we)
    begin
      rdata_d = 32'h0000_0000;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ack_q   <= 1'b0;
      hit_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q   <= ack_d;
      hit_q   <= hit_d;
      rdata_q <= rdata_d;
    end
  end

  assign cfg_ack_o   = ack_q;
  assign cfg_hit_o   = hit_q;
  assign cfg_rdata_o = rdata_q;

  // ============================================================
  // Control outputs except the restart pulse, registered once more so every pin is a flop
  // ============================================================
  logic [3:0] present;      // Ports that exist in this variant
  logic [3:0] pin_q,  pin_d;
  logic       pd_q,   pd_d;
  logic       sscd_q, sscd_d;
  logic [5:0] pllo_q, pllo_d;
  logic [5:0] osc_q,  osc_d;
  logic       hido_q, hido_d;
  logic       cap_q,  cap_d;
  logic [3:0] offo_q, offo_d;
  logic [3:0] ssf_q,  ssf_d;
  logic [3:0] hsf_q,  hsf_d;

  always_comb
  begin
    for (int p = 0; p < 4; p++)
    begin
      present[p] = (p < NUM_PORTS);
    end
    // Absent ports hold their pin at the inactive level
    pin_d  = pol_q ? (port_power_req_i & present) : ~(port_power_req_i & present);
    pd_d   = ~pol_q;
    sscd_d = ssc_q;
    pllo_d = strap_s ? pll_q : 6'h00;
    osc_d  = strap_s ? pll_q : 6'h00;
    hido_d = hide_q;
    cap_d  = ~absent_q;
    offo_d = off_q & present;
    ssf_d  = ssfix_q & present;
    hsf_d  = hsfix_q & present;
  end

  // Pins start inactive high with pulldowns on, as polarity 0 asks
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      pin_q  <= 4'hf;
      pd_q   <= 1'b1;
      sscd_q <= 1'b0;
      pllo_q <= 6'h00;
      osc_q  <= 6'h00;
      hido_q <= 1'b0;
      cap_q  <= 1'b1;
      offo_q <= 4'h0;
      ssf_q  <= 4'h0;
      hsf_q  <= 4'h0;
    end
    else
    begin
      pin_q  <= pin_d;
      pd_q   <= pd_d;
      sscd_q <= sscd_d;
      pllo_q <= pllo_d;
      osc_q  <= osc_d;
      hido_q <= hido_d;
      cap_q  <= cap_d;
      offo_q <= offo_d;
      ssf_q  <= ssf_d;
      hsf_q  <= hsf_d;
    end
  end

  assign port_power_out_pin_o     = pin_q;
  assign port_power_pulldown_en_o = pd_q;
  assign ssc_disable_o            = sscd_q;
  assign osc_restart_o            = restart_q;
  assign pll_ratio_o              = pllo_q;
  assign osc_sel_o                = osc_q;
  assign msgx_capability_hide_o   = hido_q;
  assign power_switch_capable_o   = cap_q;
  assign port_off_o               = offo_q;
  assign ss_port_fixed_o          = ssf_q;
  assign hs_port_fixed_o          = hsf_q;

  // ============================================================
  // Per-port PHY setting selection
  // ============================================================
  for (genvar g = 0; g < 4; g++)
  begin : g_port
    upc_pkg::upc_port_cfg_t pcfg;   // Slice of the three PHY registers

    assign pcfg.ovr_amp  = ovr_q[g*`UPC_PORT_STRIDE + `UPC_OVR_AMP_BIT];
    assign pcfg.ovr_de   = ovr_q[g*`UPC_PORT_STRIDE + `UPC_OVR_DE_BIT];
    assign pcfg.ovr_eq   = ovr_q[g*`UPC_PORT_STRIDE + `UPC_OVR_EQ_BIT];
    assign pcfg.amp      = tx_q[g*`UPC_PORT_STRIDE + `UPC_POS_AMP_LO +: 4];
    assign pcfg.de       = tx_q[g*`UPC_PORT_STRIDE + `UPC_POS_DE_LO +: 4];
    assign pcfg.eq_train = eq_q[g*`UPC_PORT_STRIDE + `UPC_POS_EQ_TRAIN_LO +: 4];
    assign pcfg.eq_oper  = eq_q[g*`UPC_PORT_STRIDE + `UPC_POS_EQ_OPER_LO +: 4];

    upc_phy_sel #(
      .DEF_AMP      (DEF_AMP),
      .DEF_DE       (DEF_DE),
      .DEF_EQ_TRAIN (DEF_EQ_TRAIN),
      .DEF_EQ_OPER  (DEF_EQ_OPER)
    ) u_sel (
      .sys_clk_i (sys_clk_i),
      .nrst_i    (nrst_i),
      .present_i (present[g]),
      .cfg_i     (pcfg),
      .phy_o     (port_phy_o[g])
    );
  end

endmodule : upc_regs

`default_nettype wire

// ==== logic/upc_map.svh ====
// Offsets, field positions, reset values and per-port layout of the USB port PHY control registers
`ifndef UPC_MAP_SVH
`define UPC_MAP_SVH

// ============================================================
// Register byte offsets in configuration space
// ============================================================
`define UPC_OFF_USB_CTRL      12'h0e0
`define UPC_OFF_TX_CTRL       12'h0e4
`define UPC_OFF_EQ_CTRL       12'h0e8
`define UPC_OFF_OVR_CTRL      12'h0ec

// ============================================================
// Reset values
// ============================================================
`define UPC_RST_USB_CTRL      32'h0000_0000
`define UPC_RST_TX_CTRL       32'h0000_0000
`define UPC_RST_EQ_CTRL       32'h0000_0000
`define UPC_RST_OVR_CTRL      32'h0000_0000

// ============================================================
// General control field positions
// ============================================================
`define UPC_BIT_SSC_DIS       31
`define UPC_BIT_FREQ_COMMIT   30
`define UPC_POS_PLL_HI        29
`define UPC_POS_PLL_LO        24
`define UPC_BIT_MSGX_HIDE     23
`define UPC_BIT_PWR_POL       22
`define UPC_BIT_PSW_ABSENT    16
`define UPC_POS_OFF_LO        8
`define UPC_POS_SS_FIX_LO     4
`define UPC_POS_HS_FIX_LO     0
`define UPC_BYTE_COMMIT       3

// ============================================================
// Per-port layout: each port owns one byte of the PHY registers
// ============================================================
`define UPC_PORT_STRIDE       8
`define UPC_POS_AMP_LO        4
`define UPC_POS_DE_LO         0
`define UPC_POS_EQ_TRAIN_LO   4
`define UPC_POS_EQ_OPER_LO    0
`define UPC_OVR_DE_BIT        0
`define UPC_OVR_AMP_BIT       1
`define UPC_OVR_EQ_BIT        2
`define UPC_OVR_MASK          32'h0707_0707

`endif

// ==== logic/upc_pkg.sv ====
// Types shared by the USB port PHY control register bank
`default_nettype none

package upc_pkg;

  // ============================================================
  // Sizes
  // ============================================================
  localparam int unsigned UPC_MAX_PORTS = 4;
  localparam int unsigned UPC_FLD_W     = 4;
  localparam int unsigned UPC_PLL_W     = 6;

  typedef logic [UPC_FLD_W-1:0] upc_fld_t;     // One 4-bit PHY setting

  // Configuration access from the root-complex side, one-cycle request
  typedef struct packed {
    logic        req;     // Access strobe
    logic        we;      // 1 write, 0 read
    logic [11:0] addr;    // Byte address in configuration space
    logic [3:0]  be;      // Byte enables of a write
    logic [31:0] wdata;   // Write data
  } upc_cfg_req_t;

  // Software settings of one port
  typedef struct packed {
    logic     ovr_amp;    // Amplitude override enable
    logic     ovr_de;     // De-emphasis override enable
    logic     ovr_eq;     // Equalizer override enable
    upc_fld_t amp;        // Transmit amplitude value
    upc_fld_t de;         // Transmit de-emphasis value
    upc_fld_t eq_train;   // Equalizer training value
    upc_fld_t eq_oper;    // Equalizer operational value
  } upc_port_cfg_t;

  // Settings actually driven into one port of the PHY
  typedef struct packed {
    upc_fld_t amp;
    upc_fld_t de;
    upc_fld_t eq_train;
    upc_fld_t eq_oper;
  } upc_port_phy_t;

endpackage : upc_pkg

`default_nettype wire

// ==== logic/upc_sync.sv ====
// Two-flop synchroniser for pin-level inputs
`default_nettype none

module upc_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             sys_clk_i,
  input  wire logic             nrst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  // ============================================================
  // Metastability stages
  // ============================================================
  logic [WIDTH-1:0] meta_q;   // First stage, read only by the second
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;   // Second stage, safe to use
  logic [WIDTH-1:0] sync_d;

  // Next values: a plain shift
  always_comb
  begin
    meta_d = async_i;
    sync_d = meta_q;
  end

  // Reset low so that reset pins read as asserted until proven released
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_o = sync_q;

endmodule : upc_sync

`default_nettype wire

// ==== logic/upc_phy_sel.sv ====
// Per-port choice between built-in PHY defaults and software values
`default_nettype none

module upc_phy_sel #(
  parameter upc_pkg::upc_fld_t DEF_AMP      = 4'h0,
  parameter upc_pkg::upc_fld_t DEF_DE       = 4'h0,
  parameter upc_pkg::upc_fld_t DEF_EQ_TRAIN = 4'h0,
  parameter upc_pkg::upc_fld_t DEF_EQ_OPER  = 4'h0
) (
  input  wire logic                   sys_clk_i,
  input  wire logic                   nrst_i,
  input  wire logic                   present_i,
  input  wire upc_pkg::upc_port_cfg_t cfg_i,
  output upc_pkg::upc_port_phy_t      phy_o
);

  // ============================================================
  // Selection
  // ============================================================
  upc_pkg::upc_port_phy_t phy_q;   // Registered so the PHY sees no glitch
  upc_pkg::upc_port_phy_t phy_d;

  // An absent port keeps its defaults whatever is stored for it
  always_comb
  begin
    phy_d.amp      = DEF_AMP;
    phy_d.de       = DEF_DE;
    phy_d.eq_train = DEF_EQ_TRAIN;
    phy_d.eq_oper  = DEF_EQ_OPER;
    if (present_i && cfg_i.ovr_amp)
    begin
      phy_d.amp = cfg_i.amp;
    end
    if (present_i && cfg_i.ovr_de)
    begin
      phy_d.de = cfg_i.de;
    end
    if (present_i && cfg_i.ovr_eq)
    begin
      phy_d.eq_train = cfg_i.eq_train;
      phy_d.eq_oper  = cfg_i.eq_oper;
    end
  end

  // Output register, defaults from power-on
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      phy_q <= {DEF_AMP, DEF_DE, DEF_EQ_TRAIN, DEF_EQ_OPER};
    end
    else
    begin
      phy_q <= phy_d;
    end
  end

  assign phy_o = phy_q;

endmodule : upc_phy_sel

`default_nettype wire

// ==== verification/upc_assertions.sv ====
// Checker of the USB port PHY control register bank
`default_nettype none

module upc_assertions #(
  parameter int unsigned NUM_PORTS = 4   // Ports that exist in the bound bank
) (
  input wire logic                  sys_clk_i,
  input wire logic                  nrst_i,
  input wire logic                  freq_strap_pin_i,
  input wire upc_pkg::upc_cfg_req_t cfg_req_i,
  input wire logic                  cfg_ack_o,
  input wire logic                  cfg_hit_o,
  input wire logic [31:0]           cfg_rdata_o,
  input wire logic [3:0]            port_power_req_i,
  input wire logic [3:0]            port_power_out_pin_o,
  input wire logic                  port_power_pulldown_en_o,
  input wire logic                  osc_restart_o,
  input wire logic [5:0]            pll_ratio_o,
  input wire logic [5:0]            osc_sel_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  // Absent ports keep their pins inactive whatever is requested
  localparam logic [3:0] PRESENT = 4'((1 << NUM_PORTS) - 1);
  // Set by the first commit pulse; only power-on clears it, so a second pulse shows
  logic seen_q;
  logic seen_d;
  always_comb seen_d = seen_q | osc_restart_o;
  always_ff @(posedge sys_clk_i or negedge nrst_i)
    if (!nrst_i) seen_q <= 1'b0;
    else seen_q <= seen_d;
  // ==========================================================
  // Properties
  // ==========================================================
  a_ack_after_req: assert property (cfg_req_i.req |=> cfg_ack_o) else $error("no ack");
  a_unmapped_quiet: assert property (
    cfg_req_i.req && cfg_req_i.addr > 12'h0ec |=> !cfg_hit_o && cfg_rdata_o == '0) else $error("unmapped hit");
  a_rsvd_zero: assert property (
    cfg_req_i.req && !cfg_req_i.we && cfg_req_i.addr == 12'h0e0 |=> (cfg_rdata_o & 32'h003e_f000) == '0)
    else $error("reserved bits set");
  a_low_pol_pins: assert property (
    port_power_pulldown_en_o ##1 port_power_pulldown_en_o
    |-> port_power_out_pin_o == ~($past(port_power_req_i) & PRESENT)) else $error("pin polarity");
  a_high_pol_pins: assert property (
    !port_power_pulldown_en_o ##1 !port_power_pulldown_en_o
    |-> port_power_out_pin_o == ($past(port_power_req_i) & PRESENT)) else $error("active high pin level");
  a_restart_pulse: assert property (
    osc_restart_o |-> ($past(cfg_req_i.req) && $past(cfg_req_i.we)) ##1 !osc_restart_o) else $error("bad restart pulse");
  a_commit_once: assert property (seen_q |-> !osc_restart_o) else $error("second restart");
  a_strap_gate: assert property (!freq_strap_pin_i [*5] |=> pll_ratio_o == 6'h00) else $error("pll not gated");
  a_osc_mirror: assert property (osc_sel_o == pll_ratio_o) else $error("osc select differs");
endmodule : upc_assertions

`default_nettype wire

// ==== verification/upc_rc_model.sv ====
// Root-complex model issuing configuration accesses
`default_nettype none

module upc_rc_model (
  input  wire logic             sys_clk_i,
  input  wire logic             cfg_ack_o,
  output upc_pkg::upc_cfg_req_t cfg_req_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial cfg_req_o = '0;
  // One-cycle strobe, then a bounded wait for the answer
  task automatic acc(input logic we, input logic [11:0] a, input logic [31:0] d, output bit ok);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    cfg_req_o <= '{1'b1, we, a, 4'hf, d};
    @(posedge sys_clk_i);
    cfg_req_o <= '0;
    @(posedge sys_clk_i);
    while (!cfg_ack_o && n < 4) begin
      @(posedge sys_clk_i);
      n++;
    end
    ok = cfg_ack_o;
  endtask : acc
endmodule : upc_rc_model

`default_nettype wire

// ==== verification/tb.sv ====
// Self-checking bench of the PHY control register bank
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, nrst = 0, perst = 1, global_reset_n = 1, strap = 1;
  logic [3:0] preq = '0, pin, off, ssf, hsf;
  logic ack, hit, ssc, rs, hide, cap, pd;
  logic [31:0] rdata, v, w;
  logic [5:0] pll, osc;
  upc_pkg::upc_cfg_req_t req;
  upc_pkg::upc_port_phy_t phy [4];
  logic [3:0] pin2, off2, ssf2, hsf2;
  upc_pkg::upc_port_phy_t phy2 [4];
  logic [31:0] exq [$];
  int failures, samples_checked;
  bit ok;
  always #4 clk = ~clk;
  upc_rc_model upc_rc_model_i (.sys_clk_i(clk), .cfg_ack_o(ack), .cfg_req_o(req));
  upc_regs upc_regs_i (.sys_clk_i(clk), .nrst_i(nrst), .perst_n_i(perst), .global_reset_n_i(global_reset_n),
    .freq_strap_pin_i(strap), .cfg_req_i(req), .cfg_ack_o(ack), .cfg_hit_o(hit), .cfg_rdata_o(rdata),
    .port_power_req_i(preq), .port_power_out_pin_o(pin), .port_power_pulldown_en_o(pd),
    .ssc_disable_o(ssc), .osc_restart_o(rs), .pll_ratio_o(pll), .osc_sel_o(osc),
    .msgx_capability_hide_o(hide), .power_switch_capable_o(cap), .port_off_o(off),
    .ss_port_fixed_o(ssf), .hs_port_fixed_o(hsf), .port_phy_o(phy));
  // Two-port variant on the same bus; it only listens, so its answers are left open
  upc_regs #(.NUM_PORTS(2)) upc_regs2_i (.sys_clk_i(clk), .nrst_i(nrst), .perst_n_i(perst),
    .global_reset_n_i(global_reset_n), .freq_strap_pin_i(strap), .cfg_req_i(req), .cfg_ack_o(), .cfg_hit_o(),
    .cfg_rdata_o(), .port_power_req_i(preq), .port_power_out_pin_o(pin2), .port_power_pulldown_en_o(),
    .ssc_disable_o(), .osc_restart_o(), .pll_ratio_o(), .osc_sel_o(), .msgx_capability_hide_o(),
    .power_switch_capable_o(), .port_off_o(off2), .ss_port_fixed_o(ssf2), .hs_port_fixed_o(hsf2),
    .port_phy_o(phy2));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) $display("[ERR] %0t got %h exp %h", $time, got, exp);
    if (got !== exp) failures++;
  endtask : chk
  // Read data is judged against the oldest note when the answer stands
  always @(posedge clk) if (ack) chk(rdata, exq.size() ? exq.pop_front() : 32'hdead_beef);
  task automatic test_done(input int hang);
    failures += hang;
    $display("checked %0d failed %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done
  task automatic rw(input logic we, input logic [11:0] a, input logic [31:0] d, input logic [31:0] e);
    exq.push_back(e);
    upc_rc_model_i.acc(we, a, d, ok);
    if (!ok) test_done(1);
  endtask : rw
  // Writes reach outputs two edges on, strap changes three; power requests vary meanwhile
  task automatic wt;
    preq <= 4'($urandom);
    repeat (5) @(posedge clk);
  endtask : wt
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    void'($urandom(32'h29e57b75));
    repeat (5) @(posedge clk);
    for (int i = 0; i < 5; i++) rw(0, 12'h0e0 + 12'(4 * i), '0, '0);
    $display("reset values done");
    v = $urandom;
    w = $urandom;
    rw(1, 12'h0e4, v, '0);
    rw(1, 12'h0e8, w, '0);
    for (int k = 0; k < 2; k++) begin
      rw(1, 12'h0ec, k ? 32'h0 : 32'hffff_ffff, '0);
      rw(0, 12'h0ec, '0, k ? 32'h0 : 32'h0707_0707);
      wt;
      for (int p = 0; p < 4; p++) chk(phy[p], k ? 32'h0 : {v[8*p+4+:4], v[8*p+:4], w[8*p+4+:4], w[8*p+:4]});
      for (int p = 2; p < 4; p++) chk(phy2[p], '0);
    end
    $display("phy override done");
    v = {2'b11, 6'($urandom | 1), 24'hff_ffff};
    rw(1, 12'h0e0, v, '0);
    chk(rs, 1);
    rw(0, 12'h0e0, '0, v & 32'hffc1_0fff);
    wt;
    chk({ssc, pll, osc, hide, pd, cap, off, ssf, hsf}, {1'b1, v[29:24], v[29:24], 3'b100, 12'hfff});
    chk({pin2[3:2], off2, ssf2, hsf2}, 14'h0333);
    rw(1, 12'h0e0, {2'b01, ~v[29:24], 24'h40_0000}, '0);
    chk(rs, 0);
    rw(0, 12'h0e0, '0, v & 32'h7f40_0000);
    wt;
    chk({ssc, pll, hide, pd, cap, off, ssf, hsf}, {1'b0, v[29:24], 3'b001, 12'h000});
    // Strap low must blank the PLL and oscillator selects though the field stays stored
    strap <= 1'b0;
    wt;
    chk({pll, osc}, '0);
    strap <= 1'b1;
    $display("control fields done");
    rw(1, 12'h0e0, v, '0);
    rw(1, 12'h0e4, 32'h5a5a_5a5a, '0);
    for (int k = 0; k < 2; k++) begin
      if (k) global_reset_n <= 1'b0;
      else perst <= 1'b0;
      repeat (4) @(posedge clk);
      perst <= 1'b1;
      global_reset_n <= 1'b1;
      repeat (5) @(posedge clk);
      rw(0, 12'h0e0, '0, k ? 32'h0 : v & 32'h7f40_0000);
      rw(0, 12'h0e4, '0, '0);
    end
    rw(1, 12'h0e0, 32'h4000_0000, '0);
    chk(rs, 0);
    rw(0, 12'h0e0, '0, '0);
    strap <= 1'b0;
    repeat (6) @(posedge clk);
    $display("resets done");
    test_done(0);
  end
endmodule : tb

bind upc_regs upc_assertions #(.NUM_PORTS(NUM_PORTS)) upc_assertions_i (.*);

`default_nettype wire
